// *** hw/hijx_ctrl.sv ***
// Operation
// - An all-zero config word runs the jammed instruction like normal execution.
// - Data and instruction cache block operations are accepted for injection.
// - Moves to/from CR, FP status, MACHINE_STATE_REG, PERF_MONITOR_REG, SPECIAL_PURPOSE_REG, TLB ops and wait accepted only with an all-zero config word.
// - Barrier accepted only with level field zero.
// - Next-address SPECIAL_PURPOSE_REG moves only while halted, else illegal instruction.
// - Injected instructions may change any architected register.
// - An injected exception never redirects the next instruction address.
// - Problem-state bit reads as zero during injection.
// - All loads and stores get read and write permission during injection.
// - Debug mode bit acts cleared during injection; no debug events.
// - Injected exception leaves save/restore, MACHINE_STATE_REG, syndrome, DATA_EXCEPTION_ADDRESS, MMU, DEBUG_STATUS_REG unchanged.
// - Machine check syndrome and address still update on injected exception.
// - Injected exception records its vector offset number in status register.
// - Injected exception records the would-be syndrome in external syndrome register.
// - Injected access lacking translation raises data TLB miss, recorded likewise.
// - Asynchronous interrupts stay disabled while halted.
// - Debug space select routes loads and stores through the jam data registers.
// - Injected exception sets exception flag and zeroes completed count.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hijx_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic core_halted,
    input wire logic [31:0] core_instr,
    output logic core_nia_illegal,
    output logic jam_valid,
    output logic [31:0] jam_instr,
    output logic [31:0] jam_cfg,
    input wire logic jam_ack,
    input wire logic jam_done,
    input wire logic jam_exc,
    input wire logic [5:0] jam_exc_vector,
    input wire logic [31:0] jam_exc_syndrome,
    input wire logic jam_tlb_miss,
    output logic [63:0] jam_ld_data,
    input wire logic jam_st_valid,
    input wire logic jam_st_double,
    input wire logic [63:0] jam_st_data,
    output logic debug_space_select,
    output logic jam_normal_exec,
    output logic force_priv,
    output logic grant_rw,
    input wire logic idm_in,
    output logic eff_idm,
    output logic arch_save_inhibit,
    output logic nia_hold,
    output logic async_irq_enable
);
    import hijx_pkg::*;

    // ---------------------------------------------------------------
    // Decode of jammed and pipeline instructions
    // ---------------------------------------------------------------
    logic jam_sup;
    logic jam_uses_cfg;
    logic core_nia_move;

    hijx_decode u_dec_jam (
        .instr(s_axi_wdata),
        .supported(jam_sup),
        .uses_config(jam_uses_cfg),
        .is_nia_move()
    );

    hijx_decode u_dec_core (
        .instr(core_instr),
        .supported(),
        .uses_config(),
        .is_nia_move(core_nia_move)
    );

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // AXI4-Lite channel state
    // ---------------------------------------------------------------
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0] awaddr_q, awaddr_d, araddr_reg;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire;

    // ---------------------------------------------------------------
    // Jam state
    // ---------------------------------------------------------------
    hijx_state_t state_q, state_d;
    logic [31:0] instr_q, instr_d, cfg_q, cfg_d, data0_q, data0_d, data1_q, data1_d, synd_q, synd_d;
    logic exc_flag_q, exc_flag_d, acc_err_q, acc_err_d, unsup_q, unsup_d;
    logic [5:0] vec_q, vec_d;
    logic [3:0] completed_instr_count_q, completed_instr_count_d;
    logic busy;
    logic fault;
    logic [31:0] status_word;

    assign busy = (state_q != HIJX_IDLE);
    assign fault = (state_q == HIJX_WAIT) && (jam_exc || jam_tlb_miss);
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign araddr_reg = s_axi_araddr;

    always_comb begin
        status_word = RST_WORD;
        status_word[STS_BUSY] = busy;
        status_word[STS_JAM_EXCEPTION_FLAG] = exc_flag_q;
        status_word[STS_ACCESS_ERROR] = acc_err_q;
        status_word[STS_UNSUPPORTED] = unsup_q;
        status_word[STS_VECTOR_LSB +: 6] = vec_q;
        status_word[STS_COUNT_LSB +: 4] = completed_instr_count_q;
    end

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case (awaddr_q)
                OFS_JAM_INSTR: begin
                    if (busy || !core_halted) begin
                        bresp_d = RESP_SLVERR;
                    end
                end
                OFS_JAM_CONFIG_WORD, OFS_JAM_DATA0, OFS_JAM_DATA1, OFS_EXT_DEBUG_STATUS_1,
                OFS_EXT_DEBUG_SYNDROME: begin
                    bresp_d = RESP_OKAY;
                end
                default: begin
                    bresp_d = RESP_SLVERR;
                end
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (araddr_reg)
                OFS_JAM_INSTR: rdata_d = instr_q;
                OFS_JAM_CONFIG_WORD: rdata_d = cfg_q;
                OFS_JAM_DATA0: rdata_d = data0_q;
                OFS_JAM_DATA1: rdata_d = data1_q;
                OFS_EXT_DEBUG_STATUS_1: rdata_d = status_word;
                OFS_EXT_DEBUG_SYNDROME: rdata_d = synd_q;
                default: begin
                    rdata_d = RST_WORD;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= RST_WORD;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= RST_WORD;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ---------------------------------------------------------------
    // Jam sequencing and debug registers
    // ---------------------------------------------------------------
    // Decoder looks at the live write bus, so sample its verdict when the data beat lands
    logic sup_q, sup_d;

    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        cfg_d = cfg_q;
        data0_d = data0_q;
        data1_d = data1_q;
        synd_d = synd_q;
        exc_flag_d = exc_flag_q;
        acc_err_d = acc_err_q;
        unsup_d = unsup_q;
        vec_d = vec_q;
        completed_instr_count_d = completed_instr_count_q;
        sup_d = sup_q;
        if (s_axi_wvalid && s_axi_wready) begin
            sup_d = jam_sup && (jam_uses_cfg || cfg_q == RST_WORD);
        end
        if (wr_fire) begin
            case (awaddr_q)
                OFS_JAM_INSTR: begin
                    if (!busy && core_halted) begin
                        instr_d = merge_bytes(instr_q, wdata_q, wstrb_q);
                        state_d = HIJX_ISSUE;
                        exc_flag_d = 1'b0;
                        unsup_d = !sup_q;
                    end
                end
                OFS_JAM_CONFIG_WORD: begin
                    if (!busy) begin
                        cfg_d = merge_bytes(cfg_q, wdata_q, wstrb_q);
                    end
                end
                OFS_JAM_DATA0: data0_d = merge_bytes(data0_q, wdata_q, wstrb_q);
                OFS_JAM_DATA1: data1_d = merge_bytes(data1_q, wdata_q, wstrb_q);
                OFS_EXT_DEBUG_STATUS_1: begin
                    if (wstrb_q[0] && wdata_q[STS_ACCESS_ERROR]) begin
                        acc_err_d = 1'b0;
                    end
                end
                default: begin
                    acc_err_d = acc_err_q;
                end
            endcase
            if (awaddr_q == OFS_JAM_INSTR && (busy || !core_halted)) begin
                acc_err_d = 1'b1;
            end
        end
        // Core store into debug space overrides a simultaneous bus write
        if (jam_st_valid && busy && cfg_q[CFG_DEBUG_SPACE_SELECT]) begin
            data1_d = jam_st_data[31:0];
            if (jam_st_double) begin
                data0_d = jam_st_data[63:32];
            end
        end
        case (state_q)
            HIJX_IDLE: begin
            end
            HIJX_ISSUE: begin
                if (jam_ack) begin
                    state_d = HIJX_WAIT;
                end
            end
            HIJX_WAIT: begin
                if (fault) begin
                    state_d = HIJX_IDLE;
                    exc_flag_d = 1'b1;
                    completed_instr_count_d = 4'h0;
                    acc_err_d = 1'b1;
                    vec_d = jam_tlb_miss ? VEC_DATA_TLB_MISS : jam_exc_vector;
                    synd_d = jam_exc_syndrome;
                end else if (jam_done) begin
                    state_d = HIJX_IDLE;
                end
            end
            default: begin
                state_d = HIJX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= HIJX_IDLE;
            instr_q <= RST_WORD;
            cfg_q <= RST_WORD;
            data0_q <= RST_WORD;
            data1_q <= RST_WORD;
            synd_q <= RST_WORD;
            exc_flag_q <= 1'b0;
            acc_err_q <= 1'b0;
            unsup_q <= 1'b0;
            vec_q <= 6'h00;
            completed_instr_count_q <= 4'h0;
            sup_q <= 1'b0;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            cfg_q <= cfg_d;
            data0_q <= data0_d;
            data1_q <= data1_d;
            synd_q <= synd_d;
            exc_flag_q <= exc_flag_d;
            acc_err_q <= acc_err_d;
            unsup_q <= unsup_d;
            vec_q <= vec_d;
            completed_instr_count_q <= completed_instr_count_d;
            sup_q <= sup_d;
        end
    end

    // ---------------------------------------------------------------
    // Core-facing overrides
    // ---------------------------------------------------------------
    assign jam_valid = (state_q == HIJX_ISSUE);
    assign jam_instr = instr_q;
    assign jam_cfg = cfg_q;
    assign jam_normal_exec = (cfg_q == RST_WORD);
    assign jam_ld_data = {data0_q, data1_q};
    assign debug_space_select = cfg_q[CFG_DEBUG_SPACE_SELECT];
    assign force_priv = busy;
    assign grant_rw = busy;
    assign eff_idm = idm_in && !busy;
    // Machine check syndrome/address are outside this inhibit and keep updating
    assign arch_save_inhibit = busy;
    assign nia_hold = busy;
    assign async_irq_enable = !core_halted;
    assign core_nia_illegal = core_nia_move && !core_halted;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_start_halted: assert property ($rose(jam_valid) |-> $past(core_halted))
        else $error("jam started while not halted");
    chk_busy_holds: assert property (busy && !fault && !jam_done |=> busy)
        else $error("busy dropped early");
    chk_exc_flag: assert property (fault |=> exc_flag_q && completed_instr_count_q == 4'h0 && !busy)
        else $error("exception flag or count wrong");
    chk_vector_rec: assert property (fault && !jam_tlb_miss |=> vec_q == $past(jam_exc_vector))
        else $error("vector not recorded");
    chk_syndrome_rec: assert property (fault |=> synd_q == $past(jam_exc_syndrome))
        else $error("syndrome not recorded");
    chk_tlb_vector: assert property (fault && jam_tlb_miss |=> vec_q == VEC_DATA_TLB_MISS)
        else $error("tlb miss vector wrong");
    chk_priv_override: assert property (jam_valid ##1 busy |-> force_priv && grant_rw && !eff_idm)
        else $error("overrides missing during jam");
    chk_state_inhibit: assert property (fault |-> arch_save_inhibit && nia_hold)
        else $error("state not protected on exception");
    chk_async_off: assert property (core_halted |-> !async_irq_enable)
        else $error("async interrupts enabled while halted");
    chk_nia_illegal: assert property (core_nia_move && !core_halted |-> core_nia_illegal)
        else $error("nia move not illegal");
    chk_store_space: assert property (busy && jam_st_valid && debug_space_select |=> data1_q == $past(jam_st_data[31:0]))
        else $error("debug store lost");

    cov_jam_done: cover property (state_q == HIJX_WAIT && jam_done);
    cov_jam_fault: cover property (fault && jam_tlb_miss);
    cov_refused: cover property (wr_fire && awaddr_q == OFS_JAM_INSTR && !core_halted);
    cov_store: cover property (busy && jam_st_valid && jam_st_double);

endmodule
`default_nettype wire

// *** hw/hijx_pkg.sv ***
package hijx_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_JAM_INSTR = 8'h00;
    localparam logic [7:0] OFS_JAM_CONFIG_WORD = 8'h04;
    localparam logic [7:0] OFS_JAM_DATA0 = 8'h08;
    localparam logic [7:0] OFS_JAM_DATA1 = 8'h0C;
    localparam logic [7:0] OFS_EXT_DEBUG_STATUS_1 = 8'h10;
    localparam logic [7:0] OFS_EXT_DEBUG_SYNDROME = 8'h14;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int CFG_DEBUG_SPACE_SELECT = 0;
    localparam int STS_BUSY = 0;
    localparam int STS_JAM_EXCEPTION_FLAG = 1;
    localparam int STS_ACCESS_ERROR = 2;
    localparam int STS_UNSUPPORTED = 3;
    localparam int STS_VECTOR_LSB = 4;
    localparam int STS_COUNT_LSB = 12;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0] VEC_DATA_TLB_MISS = 6'h0D;
    localparam logic [9:0] SPR_NEXT_INSTR_ADDRESS = 10'h22F;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Instruction encodings
    // ---------------------------------------------------------------
    localparam logic [5:0] OP_LWZ = 6'h20, OP_STW = 6'h24, OP_STB = 6'h26, OP_LBZ = 6'h22;
    localparam logic [5:0] OP_LHZ = 6'h28, OP_LHA = 6'h2A, OP_STH = 6'h2C, OP_LFS = 6'h30;
    localparam logic [5:0] OP_LFD = 6'h32, OP_STFS = 6'h34, OP_STFD = 6'h36;
    localparam logic [5:0] OP_EXT31 = 6'h1F, OP_EXT63 = 6'h3F;
    localparam logic [9:0] XO_DFLUSH = 10'h056, XO_DINVAL = 10'h1D6, XO_DLOCKCLR = 10'h186;
    localparam logic [9:0] XO_DSTORE = 10'h036, XO_DTOUCHLOCK = 10'h0A6, XO_DTOUCHSTLOCK = 10'h086;
    localparam logic [9:0] XO_DZERO = 10'h3F6, XO_IINVAL = 10'h3D6, XO_ILOCKCLR = 10'h0E6;
    localparam logic [9:0] XO_ITOUCHLOCK = 10'h1E6, XO_LDHALF_REV = 10'h316, XO_LDWORD_REV = 10'h216;
    localparam logic [9:0] XO_STHALF_REV = 10'h396, XO_STWORD_REV = 10'h296;
    localparam logic [9:0] XO_FROM_COND = 10'h013, XO_FROM_MSTATE = 10'h053, XO_FROM_PERF = 10'h14E;
    localparam logic [9:0] XO_FROM_SPECIAL = 10'h153, XO_TO_COND = 10'h090, XO_TO_MSTATE = 10'h092;
    localparam logic [9:0] XO_TO_PERF = 10'h1CE, XO_TO_SPECIAL = 10'h1D3, XO_BARRIER = 10'h256;
    localparam logic [9:0] XO_TLB_READ = 10'h3B2, XO_TLB_SEARCH = 10'h392, XO_TLB_WRITE = 10'h3D2;
    localparam logic [9:0] XO_WAIT = 10'h03E;
    localparam logic [9:0] XO_FROM_FSTAT = 10'h247, XO_TO_FSTAT = 10'h2C7, XO_TO_FSTAT_IMM = 10'h086;

    typedef enum logic [1:0] {
        HIJX_IDLE = 2'b00,
        HIJX_ISSUE = 2'b01,
        HIJX_WAIT = 2'b10
    } hijx_state_t;

endpackage

// *** hw/hijx_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module hijx_decode (
    input wire logic [31:0] instr,
    output logic supported,
    output logic uses_config,
    output logic is_nia_move
);
    import hijx_pkg::*;

    logic [5:0] op;
    logic [9:0] xo;
    logic [9:0] spr_num;

    assign op = instr[31:26];
    assign xo = instr[10:1];
    assign spr_num = {instr[15:11], instr[20:16]};

    always_comb begin
        supported = 1'b0;
        uses_config = 1'b0;
        is_nia_move = 1'b0;
        case (op)
            OP_LBZ, OP_LFD, OP_LFS, OP_LHA, OP_LHZ, OP_LWZ, OP_STB, OP_STFD, OP_STFS, OP_STH, OP_STW: begin
                supported = 1'b1;
                uses_config = 1'b1;
            end
            OP_EXT31: begin
                case (xo)
                    XO_DFLUSH, XO_DINVAL, XO_DLOCKCLR, XO_DSTORE, XO_DTOUCHLOCK, XO_DTOUCHSTLOCK, XO_DZERO,
                    XO_IINVAL, XO_ILOCKCLR, XO_ITOUCHLOCK: begin
                        supported = 1'b1;
                        uses_config = 1'b1;
                    end
                    XO_LDHALF_REV, XO_LDWORD_REV, XO_STHALF_REV, XO_STWORD_REV: begin
                        supported = 1'b1;
                        uses_config = 1'b1;
                    end
                    XO_FROM_COND, XO_FROM_MSTATE, XO_FROM_PERF, XO_TO_COND, XO_TO_MSTATE, XO_TO_PERF,
                    XO_TLB_READ, XO_TLB_SEARCH, XO_TLB_WRITE, XO_WAIT: begin
                        supported = 1'b1;
                    end
                    XO_FROM_SPECIAL, XO_TO_SPECIAL: begin
                        supported = 1'b1;
                        is_nia_move = (spr_num == SPR_NEXT_INSTR_ADDRESS);
                    end
                    XO_BARRIER: begin
                        supported = (instr[22:21] == 2'h0);
                    end
                    default: begin
                        supported = 1'b0;
                    end
                endcase
            end
            OP_EXT63: begin
                supported = (xo == XO_FROM_FSTAT) || (xo == XO_TO_FSTAT) || (xo == XO_TO_FSTAT_IMM);
            end
            default: begin
                supported = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// *** test/hijx_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hijx_core_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic jam_valid,
    input wire logic [1:0] mode,
    input wire logic do_st,
    output logic jam_ack,
    output logic jam_done,
    output logic jam_exc,
    output logic jam_tlb_miss,
    output logic jam_st_valid,
    output logic jam_st_double,
    output logic [5:0] jam_exc_vector,
    output logic [31:0] jam_exc_syndrome,
    output logic [63:0] jam_st_data
);
    // ----
    // Slow core: two idle cycles before ack and finish
    // ----
    logic [1:0] cnt_q;
    logic ph_q;
    logic fin;
    assign fin = jam_done | jam_exc | jam_tlb_miss;
    // Payloads garbage outside their strobe
    assign jam_exc_vector = fin ? 6'h05 : 6'h3A;
    assign jam_exc_syndrome = fin ? 32'h0080_0000 : 32'hFF7F_FFFF;
    assign jam_st_data = jam_st_valid ? 64'h0000_0000_CAFE_F00D : 64'hFFFF_FFFF_3501_0FF2;
    assign jam_st_double = 1'h0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {cnt_q, ph_q, jam_ack, jam_done, jam_exc, jam_tlb_miss, jam_st_valid} <= 8'h0;
        end else begin
            {jam_ack, jam_done, jam_exc, jam_tlb_miss, jam_st_valid} <= 5'h0;
            if ((jam_valid && !jam_ack) || ph_q) begin
                cnt_q <= cnt_q + 2'h1;
                if (cnt_q == 2'h2) begin
                    cnt_q <= 2'h0;
                    ph_q <= !ph_q;
                    jam_ack <= !ph_q;
                    jam_done <= ph_q && mode == 2'h0;
                    jam_exc <= ph_q && mode == 2'h1;
                    jam_tlb_miss <= ph_q && mode == 2'h2;
                    jam_st_valid <= ph_q && do_st;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hijx_pkg::*;
    logic clk_sys = 0, rst_b = 0, core_halted = 1, idm_in = 1, do_st = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, core_instr = 0, s_axi_rdata, jam_instr, jam_cfg, jam_exc_syndrome;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_nia_illegal, jam_valid;
    logic jam_ack, jam_done, jam_exc, jam_tlb_miss, jam_st_valid, jam_st_double, debug_space_select;
    logic jam_normal_exec, force_priv, grant_rw, eff_idm, arch_save_inhibit, nia_hold, async_irq_enable;
    logic [5:0] jam_exc_vector, vec;
    logic [63:0] jam_ld_data, jam_st_data;
    int err_count = 0, checked = 0, m;
    hijx_ctrl dut (.*);
    hijx_core_model core (.*);
    always #10 clk_sys = ~clk_sys;
    // ----
    // Bus and check tasks
    // ----
    task automatic final_report;
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        logic ah, wh, hit;
        logic [31:0] q;
        logic [1:0] p;
        if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        else {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            ah = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
            wh = s_axi_wvalid & s_axi_wready;
            hit = w ? s_axi_bvalid : s_axi_rvalid;
            {q, p} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
            @(posedge clk_sys);
            if (ah && w) s_axi_awvalid <= 1'h0;
            if (ah && !w) s_axi_arvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
            if (hit) break;
        end
        if (k == 40) begin
            err_count++;
            final_report;
        end
        chk({30'h0, p}, {30'h0, r});
        if (!w) chk(q, d);
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            if (!force_priv) break;
        end
        @(posedge clk_sys);
        if (k == 40) begin
            err_count++;
            final_report;
        end
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(posedge clk_sys);
        bus(0, OFS_EXT_DEBUG_STATUS_1, RST_WORD, RESP_OKAY);
        bus(0, 8'h40, 32'h0, RESP_SLVERR);
        bus(1, OFS_JAM_CONFIG_WORD, 32'h0, RESP_OKAY);
        chk({31'h0, jam_normal_exec}, 32'h1);
        bus(1, OFS_JAM_DATA1, 32'h0123_4567, RESP_OKAY);
        bus(1, OFS_JAM_CONFIG_WORD, 32'h1, RESP_OKAY);
        chk({debug_space_select, jam_ld_data[31:0]}, 32'h0123_4567 | 33'h1_0000_0000);
        $display("config done");
        bus(1, OFS_JAM_INSTR, 32'h8000_0000, RESP_OKAY);
        @(negedge clk_sys);
        chk({force_priv, grant_rw, eff_idm, nia_hold, arch_save_inhibit}, 32'h1B);
        bus(1, OFS_JAM_INSTR, 32'h8000_0000, RESP_SLVERR);
        idle;
        chk({31'h0, eff_idm}, 32'h1);
        bus(0, OFS_EXT_DEBUG_STATUS_1, 32'h4, RESP_OKAY);
        do_st <= 1'h1;
        bus(1, OFS_JAM_INSTR, 32'h9000_0000, RESP_OKAY);
        idle;
        do_st <= 1'h0;
        bus(0, OFS_JAM_DATA1, 32'hCAFE_F00D, RESP_OKAY);
        $display("jam done");
        for (m = 1; m < 3; m++) begin
            vec = (m == 1) ? 6'h05 : VEC_DATA_TLB_MISS;
            mode <= m[1:0];
            bus(1, OFS_EXT_DEBUG_STATUS_1, 32'h4, RESP_OKAY);
            bus(1, OFS_JAM_INSTR, 32'h8000_0000, RESP_OKAY);
            idle;
            bus(0, OFS_EXT_DEBUG_STATUS_1, {22'h0, vec, 4'h6}, RESP_OKAY);
            bus(0, OFS_EXT_DEBUG_SYNDROME, 32'h0080_0000, RESP_OKAY);
        end
        mode <= 2'h0;
        bus(1, OFS_EXT_DEBUG_STATUS_1, 32'h4, RESP_OKAY);
        bus(1, OFS_JAM_INSTR, 32'h7C20_04AC, RESP_OKAY);
        chk(jam_instr, 32'h7C20_04AC);
        idle;
        bus(0, OFS_EXT_DEBUG_STATUS_1, {22'h0, VEC_DATA_TLB_MISS, 4'h8}, RESP_OKAY);
        bus(1, OFS_JAM_INSTR, 32'h7C00_00AC, RESP_OKAY);
        chk(jam_cfg, 32'h1);
        idle;
        bus(0, OFS_EXT_DEBUG_STATUS_1, {22'h0, VEC_DATA_TLB_MISS, 4'h0}, RESP_OKAY);
        $display("exception done");
        core_halted <= 1'h0;
        core_instr <= 32'h7C0F_8AA6;
        bus(1, OFS_JAM_INSTR, 32'h8000_0000, RESP_SLVERR);
        chk({30'h0, core_nia_illegal, async_irq_enable}, 32'h3);
        core_halted <= 1'h1;
        @(negedge clk_sys);
        chk({30'h0, core_nia_illegal, async_irq_enable}, 32'h0);
        $display("halt done");
        final_report;
    end
endmodule
`default_nettype wire
